// ==== ipv_ctrl.sv ====
// Added by the designer: the register addresses and the APB interface to the registers.
`include "ipv_cfg.svh"

module ipv_ctrl #(
   parameter int TDIS_W = 14
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output      logic [31:0]                prdata,
   output      logic                       pready,
   output      logic                       pslverr,
   input  wire logic [`IPV_NUM_SRC-1:0]    source_event,
   input  wire logic [`IPV_NUM_TRAP-1:0]   trap_event,
   output      ipv_pkg::ipv_offer_type     offer,
   input  wire logic                       cpu_accept,
   input  wire logic                       cpu_return,
   output      logic [3:0]                 cpu_level,
   output      logic                       irq
);

   // ****************************************************************
   // elaboration check
   // ****************************************************************
   if (TDIS_W < 1 || TDIS_W > 16) begin : g_bad_width
      $error("TDIS_W must lie between 1 and 16");
   end

   ipv_pkg::ipv_state_type s;
   ipv_pkg::ipv_state_type next_s;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // priority field of source i; order dma6, dma7, can1, can2
   function automatic logic [2:0] prio_of(input logic [15:0] reg17, input int i);
      prio_of = reg17[4*i +: 3];
   endfunction

   // vector index of source i
   function automatic logic [6:0] vec_of(input int i);
      case (i)
         0:       vec_of = `IPV_VEC_DMA6;
         1:       vec_of = `IPV_VEC_DMA7;
         2:       vec_of = `IPV_VEC_CAN1TX;
         default: vec_of = `IPV_VEC_CAN2TX;
      endcase
   endfunction

   // register read mux
   function automatic logic [31:0] read_of(input ipv_pkg::ipv_state_type st,
                                           input logic [7:0] a);
      read_of = 32'h0000_0000;
      case (a)
         `IPV_OFF_PRIO17:   read_of[15:0] = st.priority_ctrl_17 & `IPV_PRIO_MASK;
         `IPV_OFF_LVLVEC: begin
            read_of[11:8] = st.new_cpu_level;
            read_of[6:0]  = st.pending_vector_index;
         end
         `IPV_OFF_CTRL1: begin
            read_of[`IPV_NEST_BIT]         = st.nesting_disable;
            read_of[`IPV_NUM_TRAP-1:0]     = st.trap_flags;
         end
         `IPV_OFF_FLAG:     read_of[`IPV_NUM_SRC-1:0] = st.source_flags;
         `IPV_OFF_ENABLE:   read_of[`IPV_NUM_SRC-1:0] = st.source_enables;
         `IPV_OFF_STATUS: begin
            read_of[7:0] = st.status_low_byte;
            read_of[8]   = st.level_hi;
         end
         `IPV_OFF_TDIS:     read_of[15:0] = st.disable_count;
         `IPV_OFF_EVT:      read_of[1:0]  = st.evt;
         `IPV_OFF_EVT_MASK: read_of[1:0]  = st.evt_mask;
         default:           read_of = 32'h0000_0000;
      endcase
   endfunction

   // address decode
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         `IPV_OFF_PRIO17, `IPV_OFF_LVLVEC, `IPV_OFF_CTRL1, `IPV_OFF_FLAG,
         `IPV_OFF_ENABLE, `IPV_OFF_STATUS, `IPV_OFF_TDIS, `IPV_OFF_EVT,
         `IPV_OFF_EVT_MASK: mapped = 1'b1;
         default:           mapped = 1'b0;
      endcase
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic        wr;
      logic        setup;
      logic [3:0]  cur_lvl;
      logic [3:0]  floor_lvl;
      logic [2:0]  best_lvl;
      logic [6:0]  best_vec;
      logic        trap_hit;
      logic [3:0]  trap_lvl;
      logic [6:0]  trap_vec;
      logic        take;
      logic        give_back;
      logic [8:0]  frame;
      logic [3:0]  lvl_new;
      logic [`IPV_NUM_SRC-1:0]  src_clr;
      logic [`IPV_NUM_TRAP-1:0] trap_clr;
      logic [1:0]  evt_clr;
      logic [1:0]  evt_set;

      next_s    = s;
      wr        = psel && penable && pwrite;
      setup     = psel && !penable;
      src_clr   = '0;
      trap_clr  = '0;
      evt_clr   = 2'h0;
      evt_set   = 2'h0;
      frame     = 9'h000;
      lvl_new   = 4'h0;

      // current cpu level from status low byte and top bit
      cur_lvl = {s.level_hi, s.status_low_byte[`IPV_LVL_LSB +: 3]};

      // effective floor from nesting and timed disable
      floor_lvl = cur_lvl;
      if (s.nesting_disable && s.depth != 4'h0 && floor_lvl < `IPV_USER_MAX_LVL) begin
         floor_lvl = `IPV_USER_MAX_LVL;
      end
      if (s.disable_count != 16'h0000 && floor_lvl < `IPV_TDIS_FLOOR) begin
         floor_lvl = `IPV_TDIS_FLOOR;
      end

      // highest user source; ties go to the lower index
      best_lvl = 3'h0;
      best_vec = 7'h00;
      for (int i = 0; i < `IPV_NUM_SRC; i++) begin
         if (s.source_flags[i] && s.source_enables[i]
             && prio_of(s.priority_ctrl_17, i) > best_lvl) begin
            best_lvl = prio_of(s.priority_ctrl_17, i);
            best_vec = vec_of(i);
         end
      end

      // traps at levels 8 to 15, highest wins, above any user floor
      trap_hit = 1'b0;
      trap_lvl = 4'h0;
      trap_vec = 7'h00;
      for (int i = 0; i < `IPV_NUM_TRAP; i++) begin
         if (s.trap_flags[i] && (4'h8 | 4'(i)) > cur_lvl) begin
            trap_hit = 1'b1;
            trap_lvl = 4'h8 | 4'(i);
            trap_vec = `IPV_VEC_TRAP0 + 7'(i);
         end
      end

      // accept and return handshakes; return has precedence
      give_back = cpu_return && s.depth != 4'h0;
      take      = cpu_accept && s.offer.valid && !give_back;

      if (give_back) begin
         frame                  = s.stack[s.depth - 4'h1];
         next_s.depth           = s.depth - 4'h1;
         next_s.level_hi        = frame[8];
         next_s.status_low_byte = frame[7:0];
         evt_set[1]             = 1'b1;
      end else if (take) begin
         lvl_new                     = s.offer.level;
         next_s.stack[s.depth]       = {s.level_hi, s.status_low_byte};
         next_s.depth                = s.depth + 4'h1;
         next_s.level_hi             = lvl_new[3];
         next_s.status_low_byte[`IPV_LVL_LSB +: 3] = lvl_new[2:0];
         next_s.new_cpu_level        = lvl_new;
         next_s.pending_vector_index = s.offer.vector_index;
         evt_set[0]                  = 1'b1;
      end

      // offer, registered; withdrawn on the accepting edge
      next_s.offer = '0;
      if (!take && !give_back && s.depth < 4'(`IPV_STACK_DEPTH)) begin
         if (trap_hit) begin
            next_s.offer.valid        = 1'b1;
            next_s.offer.vector_index = trap_vec;
            next_s.offer.level        = trap_lvl;
         end else if (best_lvl != 3'h0 && {1'b0, best_lvl} > floor_lvl) begin
            next_s.offer.valid        = 1'b1;
            next_s.offer.vector_index = best_vec;
            next_s.offer.level        = {1'b0, best_lvl};
         end
      end

      // timed disable counter runs down
      if (s.disable_count != 16'h0000) begin
         next_s.disable_count = s.disable_count - 16'h0001;
      end

      // register writes
      if (wr) begin
         case (paddr)
            `IPV_OFF_PRIO17:
               next_s.priority_ctrl_17 = pwdata[15:0] & `IPV_PRIO_MASK;
            `IPV_OFF_CTRL1: begin
               next_s.nesting_disable = pwdata[`IPV_NEST_BIT];
               trap_clr               = pwdata[`IPV_NUM_TRAP-1:0];
            end
            `IPV_OFF_FLAG:
               src_clr = pwdata[`IPV_NUM_SRC-1:0];
            `IPV_OFF_ENABLE:
               next_s.source_enables = pwdata[`IPV_NUM_SRC-1:0];
            `IPV_OFF_STATUS:
               if (!give_back && !take) begin
                  next_s.status_low_byte = pwdata[7:0];
               end
            `IPV_OFF_TDIS:
               next_s.disable_count = 16'(pwdata[TDIS_W-1:0]);
            `IPV_OFF_EVT:
               evt_clr = pwdata[1:0];
            `IPV_OFF_EVT_MASK:
               next_s.evt_mask = pwdata[1:0];
            default: begin
            end
         endcase
      end

      // sticky flags: a new event wins over a clear in the same cycle
      next_s.source_flags = (s.source_flags & ~src_clr) | source_event;
      next_s.trap_flags   = (s.trap_flags & ~trap_clr) | trap_event;
      next_s.evt          = (s.evt & ~evt_clr) | evt_set;

      // read data and error captured in the setup cycle
      if (setup) begin
         next_s.rdata  = pwrite ? 32'h0000_0000 : read_of(s, paddr);
         next_s.slverr = !mapped(paddr);
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s                  <= '0;
         s.priority_ctrl_17 <= `IPV_PRIO_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign prdata    = s.rdata;
   assign pready    = 1'b1;            // zero wait states
   assign pslverr   = s.slverr && psel && penable;
   assign offer     = s.offer;
   assign cpu_level = {s.level_hi, s.status_low_byte[`IPV_LVL_LSB +: 3]};
   assign irq       = |(s.evt & s.evt_mask);

endmodule

// ==== ipv_cfg.svh ====
// Summary of operation
// - priority fields are three bits; 111 is level 7, 001 is level 1
// - a source whose priority field is zero is never offered to the cpu
// - every user priority field resets to level 4 (binary 100)
// - priority register 17 bits 14-12 can2 transmit, bits 10-8 can1 transmit
// - same register bits 6-4 dma channel 7 done, bits 2-0 dma channel 6 done
// - unimplemented priority and status bits ignore writes and read zero
// - status bits 11-8 show the new cpu level 0 to 15, reset zero
// - status bits 6-0 show the pending vector minus 8, vectors 8 to 135
// - nesting disable at control bit 15 stops a user source preempting any handler; traps still preempt
// - a source requests only while its enable bit is set
// - a flag still set after return raises the same interrupt again
// - return restores saved status low byte and old level
// - a trap re-enters until software clears its trap status flag
// - cpu level 7, set by oring 0x0E into status low byte, blocks users
// - traps use levels 8 to 15 and no disable mechanism blocks them
// - timed disable masks levels 1 to 6 for a period; level 7 still taken
`ifndef IPV_CFG_SVH
`define IPV_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define IPV_OFF_PRIO17      8'h00
`define IPV_OFF_LVLVEC      8'h04
`define IPV_OFF_CTRL1       8'h08
`define IPV_OFF_FLAG        8'h0C
`define IPV_OFF_ENABLE      8'h10
`define IPV_OFF_STATUS      8'h14
`define IPV_OFF_TDIS        8'h18
`define IPV_OFF_EVT         8'h1C
`define IPV_OFF_EVT_MASK    8'h20

// ****************************************************************
// fields and reset values
// ****************************************************************
`define IPV_PRIO_MASK       16'h7777
`define IPV_PRIO_RESET      16'h4444
`define IPV_NEST_BIT        15
`define IPV_LVL_LSB         1
`define IPV_ILR_LSB         8
`define IPV_VEC_BASE        8
`define IPV_USER_MAX_LVL    4'h7
`define IPV_TDIS_FLOOR      4'h6
`define IPV_STACK_DEPTH     8
`define IPV_NUM_SRC         4
`define IPV_NUM_TRAP        8

// ****************************************************************
// vector indices (vector number minus 8)
// ****************************************************************
`define IPV_VEC_TRAP0       7'h00
`define IPV_VEC_DMA6        7'h40
`define IPV_VEC_DMA7        7'h41
`define IPV_VEC_CAN1TX      7'h42
`define IPV_VEC_CAN2TX      7'h43

`endif

// ==== ipv_pkg.sv ====
`include "ipv_cfg.svh"

package ipv_pkg;

   // ****************************************************************
   // offer to the cpu
   // ****************************************************************
   typedef struct packed {
      logic       valid;
      logic [6:0] vector_index;
      logic [3:0] level;
   } ipv_offer_type;

   // saved context: old top level bit and status low byte
   typedef struct packed {
      logic       level_hi;
      logic [7:0] status_low_byte;
   } ipv_frame_type;

   // ****************************************************************
   // whole state of the block
   // ****************************************************************
   typedef struct packed {
      logic [15:0]                                   priority_ctrl_17;
      logic [`IPV_NUM_SRC-1:0]                       source_flags;
      logic [`IPV_NUM_SRC-1:0]                       source_enables;
      logic                                          nesting_disable;
      logic [`IPV_NUM_TRAP-1:0]                      trap_flags;
      logic [7:0]                                    status_low_byte;
      logic                                          level_hi;
      logic [`IPV_STACK_DEPTH-1:0][8:0]              stack;
      logic [3:0]                                    depth;
      logic [15:0]                                   disable_count;
      logic [3:0]                                    new_cpu_level;
      logic [6:0]                                    pending_vector_index;
      ipv_offer_type                                 offer;
      logic [1:0]                                    evt;
      logic [1:0]                                    evt_mask;
      logic [31:0]                                   rdata;
      logic                                          slverr;
   } ipv_state_type;

endpackage

// ==== ipv_chk.sv ====
`include "ipv_cfg.svh"

module ipv_chk (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire ipv_pkg::ipv_offer_type offer,
   input wire logic                   cpu_accept,
   input wire logic                   cpu_return,
   input wire logic [3:0]             cpu_level
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ****************************************************************
   // offer, take and return
   // ****************************************************************
   sequence take_s;
      cpu_accept && offer.valid && !cpu_return;
   endsequence
   sequence take_ret_s;
      take_s ##1 (cpu_return && !cpu_accept);
   endsequence

   level_above_a: assert property (offer.valid |-> offer.level > $past(cpu_level))
      else $error("offer not above cpu level");
   accept_level_a: assert property (take_s |=> cpu_level == $past(offer.level))
      else $error("cpu level not set to taken level");
   take_drop_a: assert property (take_s |=> !offer.valid)
      else $error("offer still valid after take");
   level_nonzero_a: assert property (offer.valid |-> offer.level != 4'h0)
      else $error("level zero offered");
   trap_level_a: assert property (offer.valid && offer.vector_index < 7'h08
      |-> offer.level == {1'b1, offer.vector_index[2:0]})
      else $error("trap offered at wrong level");
   user_level_a: assert property (offer.valid && offer.vector_index >= 7'h40
      |-> offer.level inside {[4'h1:4'h7]})
      else $error("user source outside levels 1 to 7");
   block_users_a: assert property (offer.valid && $past(cpu_level) == 4'h7
      |-> offer.level[3])
      else $error("user offered at cpu level 7");
   return_back_a: assert property (take_ret_s |=> cpu_level == $past(cpu_level, 2))
      else $error("return did not restore level");
   reset_level_a: assert property ($rose(presetn) |-> cpu_level == 4'h0 && !offer.valid)
      else $error("level or offer not clear after reset");
endmodule

// ==== ipv_cpu.sv ====
module ipv_cpu (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire ipv_pkg::ipv_offer_type offer,
   input  wire logic                   take_en,
   input  wire logic                   slow,
   input  wire logic                   ret_req,
   output      logic                   cpu_accept,
   output      logic                   cpu_return,
   output      logic [10:0]            last_take,
   output      logic [7:0]             taken
);
   logic [1:0] wait_cnt;

   // takes an offer at once or after a pause, returns on request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {cpu_accept, cpu_return, last_take, taken, wait_cnt} <= '0;
      end else begin
         cpu_accept <= 1'b0;
         cpu_return <= ret_req;
         if (offer.valid && take_en && !cpu_accept && !ret_req) begin
            if (slow && wait_cnt != 2'h2) begin
               wait_cnt <= wait_cnt + 2'h1;
            end else begin
               cpu_accept <= 1'b1;
               wait_cnt <= 2'h0;
            end
         end
         if (cpu_accept && offer.valid) begin
            taken <= taken + 8'h01;
            last_take <= {offer.level, offer.vector_index};
         end
      end
   end
endmodule

// ==== interrupt_priority_and_vector_status_tb_top.sv ====
`include "ipv_cfg.svh"

module interrupt_priority_and_vector_status_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic                   pclk = 1'b0;
   logic                   presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic                   cpu_accept, cpu_return, slow, ret_req;
   logic [7:0]             paddr, trap_event, taken, t0;
   logic [31:0]            pwdata, prdata, d, q;
   logic [3:0]             source_event, cpu_level;
   logic [2:0]             lv;
   logic [10:0]            last_take;
   ipv_pkg::ipv_offer_type offer;
   int                     failures, cmp_count;

   always #12.5 pclk = ~pclk;

   ipv_ctrl ipv_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .source_event(source_event), .trap_event(trap_event),
      .offer(offer), .cpu_accept(cpu_accept), .cpu_return(cpu_return),
      .cpu_level(cpu_level), .irq(irq));
   ipv_cpu ipv_cpu_i (.pclk(pclk), .presetn(presetn), .offer(offer), .take_en(1'b1),
      .slow(slow), .ret_req(ret_req), .cpu_accept(cpu_accept), .cpu_return(cpu_return),
      .last_take(last_take), .taken(taken));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] prio_word(input int i, input logic [2:0] l);
      return 32'(l) << (4 * i);
   endfunction
   function automatic logic [31:0] lv_vec(input logic [3:0] l, input logic [6:0] v);
      return {20'h0, l, 1'b0, v};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);  // let a write settle before live outputs are looked at
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, q, x);
   endtask
   task automatic ev(input logic [3:0] s, input logic [7:0] t);
      @(posedge pclk);
      source_event <= s;
      trap_event <= t;
      @(posedge pclk);
      source_event <= 4'h0;
      trap_event <= 8'h00;
      repeat (8) @(posedge pclk);
   endtask
   task automatic ret();
      @(posedge pclk);
      ret_req <= 1'b1;
      @(posedge pclk);
      ret_req <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {presetn, psel, penable, pwrite, slow, ret_req} = '0;
      {paddr, pwdata, source_event, trap_event} = '0;
      d = $urandom(9);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("prio reset", `IPV_OFF_PRIO17, 32'h4444);
      rd_chk("lvlvec reset", `IPV_OFF_LVLVEC, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", {31'h0, e}, 32'h1);
      apb(1'b1, `IPV_OFF_PRIO17, 32'hFFFFFFFF);
      rd_chk("prio mask", `IPV_OFF_PRIO17, 32'h7777);
      for (int i = 0; i < 6; i++) begin
         d = $urandom;
         apb(1'b1, `IPV_OFF_PRIO17, d);
         rd_chk("prio rand", `IPV_OFF_PRIO17, d & 32'h7777);
      end
      apb(1'b1, `IPV_OFF_LVLVEC, 32'hFFFF);
      rd_chk("lvlvec ro", `IPV_OFF_LVLVEC, 32'h0);
      apb(1'b1, `IPV_OFF_EVT_MASK, 32'h1);
      apb(1'b1, `IPV_OFF_ENABLE, 32'hF);
      // each source field at a random level, prompt and slow cpu
      for (int i = 0; i < 4; i++) begin
         lv = 3'($urandom_range(7, 1));
         slow <= i[0];
         apb(1'b1, `IPV_OFF_PRIO17, prio_word(i, lv));
         ev(4'(1 << i), 8'h00);
         rd_chk("lvlvec", `IPV_OFF_LVLVEC, lv_vec({1'b0, lv}, 7'h40 + 7'(i)));
         chk("level", {28'h0, cpu_level}, {29'h0, lv});
         chk("last take", {21'h0, last_take}, {21'h0, 1'b0, lv, 7'h40 + 7'(i)});
         chk("irq set", {31'h0, irq}, 32'h1);
         apb(1'b1, `IPV_OFF_FLAG, 32'hF);
         ret();
         chk("level back", {28'h0, cpu_level}, 32'h0);
      end
      apb(1'b1, `IPV_OFF_EVT, 32'h3);
      chk("irq clear", {31'h0, irq}, 32'h0);
      // flag left set: same source comes back after return, irq masked
      apb(1'b1, `IPV_OFF_EVT_MASK, 32'h0);
      apb(1'b1, `IPV_OFF_PRIO17, 32'h0005);
      slow <= 1'b0;
      t0 = taken;
      // return requested on the accepting edge: taken, returned, taken again
      fork
         ev(4'h1, 8'h00);
         begin
            @(posedge pclk iff offer.valid);
            ret_req <= 1'b1;
            @(posedge pclk);
            ret_req <= 1'b0;
         end
      join
      chk("reentry", {24'h0, taken}, {24'h0, t0 + 8'h02});
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, `IPV_OFF_FLAG, 32'hF);
      ret();
      // zero level and disabled source are never taken
      apb(1'b1, `IPV_OFF_PRIO17, 32'h0070);
      apb(1'b1, `IPV_OFF_ENABLE, 32'hD);
      t0 = taken;
      ev(4'h3, 8'h00);
      chk("no take", {24'h0, taken}, {24'h0, t0});
      apb(1'b1, `IPV_OFF_FLAG, 32'hF);
      // cpu level 7 blocks users, trap still taken
      apb(1'b1, `IPV_OFF_STATUS, 32'h0E);
      chk("level 7", {28'h0, cpu_level}, 32'h7);
      apb(1'b1, `IPV_OFF_PRIO17, 32'h7777);
      apb(1'b1, `IPV_OFF_ENABLE, 32'hF);
      t0 = taken;
      ev(4'h1, 8'h04);
      rd_chk("trap", `IPV_OFF_LVLVEC, lv_vec(4'hA, 7'h02));
      apb(1'b1, `IPV_OFF_CTRL1, 32'h04);
      ret();
      chk("trap once", {24'h0, taken}, {24'h0, t0 + 8'h01});
      chk("level kept", {28'h0, cpu_level}, 32'h7);
      apb(1'b1, `IPV_OFF_FLAG, 32'hF);
      apb(1'b1, `IPV_OFF_STATUS, 32'h0);
      // timed disable passes level 7 only
      apb(1'b1, `IPV_OFF_TDIS, 32'h200);
      apb(1'b1, `IPV_OFF_PRIO17, 32'h0076);
      t0 = taken;
      ev(4'h3, 8'h00);
      rd_chk("tdis", `IPV_OFF_LVLVEC, lv_vec(4'h7, 7'h41));
      chk("tdis once", {24'h0, taken}, {24'h0, t0 + 8'h01});
      // level 6 flag left set stays blocked while the count runs
      apb(1'b1, `IPV_OFF_FLAG, 32'h2);
      ret();
      chk("tdis holds 6", {24'h0, taken}, {24'h0, t0 + 8'h01});
      apb(1'b1, `IPV_OFF_FLAG, 32'hF);
      // nesting disabled: higher level waits for the handler
      apb(1'b1, `IPV_OFF_TDIS, 32'h0);
      apb(1'b1, `IPV_OFF_CTRL1, 32'h8000);
      apb(1'b1, `IPV_OFF_PRIO17, 32'h0063);
      t0 = taken;
      ev(4'h1, 8'h00);
      ev(4'h2, 8'h00);
      chk("no nest", {24'h0, taken}, {24'h0, t0 + 8'h01});
      chk("nest level", {28'h0, cpu_level}, 32'h3);
      // reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("prio rst2", `IPV_OFF_PRIO17, 32'h4444);
      wrap_up();
   end

   // cuts a hang short
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      wrap_up();
   end
endmodule

bind ipv_ctrl ipv_chk ipv_chk_i (.pclk(pclk), .presetn(presetn), .offer(offer),
   .cpu_accept(cpu_accept), .cpu_return(cpu_return), .cpu_level(cpu_level));
